// >>> logic/link_cmd_reg.sv
// command register of a link interface capability block, both layouts
`timescale 1ns/1ns
`default_nettype none
`include "link_cmd_cfg.svh"

module link_cmd_reg #(
  parameter bit                   IS_HOST     = 1'b0,
  parameter link_cmd_pkg::unit_id_t UNIT_COUNT = 5'h01,
  parameter int                   STALL_LIMIT = `LCR_STALL_LIMIT
) (
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_rst,
  input  wire logic                       i_warm_rst,
  input  wire logic                       i_cfg_wr,
  input  wire logic                       i_cfg_rd,
  input  wire logic [7:0]                 i_cfg_addr,
  input  wire logic [1:0]                 i_cfg_be,
  input  wire logic [15:0]                i_cfg_wdata,
  input  wire logic                       i_cfg_link,
  input  wire logic                       i_cfg_from_chain,
  input  wire logic [4:0]                 i_cfg_dev,
  input  wire logic [1:0]                 i_link_eoc,
  input  wire logic [1:0]                 i_rx_init_ok,
  input  wire logic [1:0]                 i_tx_init_ok,
  input  wire logic [1:0]                 i_pkt_pending,
  input  wire logic                       i_far_eoc_err,
  output logic [15:0]                     o_cfg_rdata,
  output logic                            o_cfg_rvalid,
  output logic                            o_cfg_claim,
  output logic                            o_cfg_as_eoc,
  output link_cmd_pkg::unit_id_t          o_unit_id,
  output logic                            o_bridge_flag,
  output logic                            o_req_link,
  output logic                            o_cold_reset_sel,
  output logic [1:0]                      o_init_done,
  output link_cmd_pkg::link_action_e      o_link_action [2]
);

  // ---------------- access decode ----------------
  wire logic       addr_hit;   // command register addressed
  wire logic       hit_wr;     // any write to the register
  wire logic       wr_lo;      // low byte written
  wire logic       wr_hi;      // high byte written
  wire logic       hit_rd;     // read of the register
  wire logic       wr_slave;   // write in slave layout
  wire logic       wr_host;    // write in host layout

  assign addr_hit = (i_cfg_addr == `LCR_CMD_OFFSET);
  assign hit_wr   = i_cfg_wr & addr_hit;
  assign wr_lo    = hit_wr & i_cfg_be[0];
  assign wr_hi    = hit_wr & i_cfg_be[1];
  assign hit_rd   = i_cfg_rd & addr_hit;
  assign wr_slave = ~IS_HOST;
  assign wr_host  = IS_HOST;

  // layout chosen by the fixed type code; other codes are not this block
  wire logic [2:0] type_code;  // read-only type field
  assign type_code = IS_HOST ? `LCR_TYPE_HOST : `LCR_TYPE_SLAVE;

  // ---------------- slave layout state ----------------
  link_cmd_pkg::unit_id_t base_q;    // lowest_owned_identifier
  logic                   master_q;  // link toward the master host
  logic                   dir_q;     // default request direction
  logic                   drop_q;    // drop on uninitialised link, both layouts

  // base identifier: warm and cold reset clear it
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      base_q <= `LCR_RST_BASE;
    end else if (i_warm_rst) begin
      base_q <= `LCR_RST_BASE;
    end else if (wr_lo & wr_slave) begin
      base_q <= i_cfg_wdata[`LCR_BASE_MSB:`LCR_BASE_LSB];
    end
  end

  // master link: loaded on every write, never from the data
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      master_q <= `LCR_RST_BIT;
    end else if (i_warm_rst) begin
      master_q <= `LCR_RST_BIT;
    end else if (hit_wr & wr_slave) begin
      master_q <= i_cfg_link;
    end
  end

  // default direction, warm cleared
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      dir_q <= `LCR_RST_BIT;
    end else if (i_warm_rst) begin
      dir_q <= `LCR_RST_BIT;
    end else if (wr_hi & wr_slave) begin
      dir_q <= i_cfg_wdata[`LCR_DIR_BIT];
    end
  end

  // drop control, cold reset only, same bit in both layouts
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      drop_q <= `LCR_RST_BIT;
    end else if (wr_hi) begin
      drop_q <= i_cfg_wdata[`LCR_DROP_BIT];
    end
  end

  // ---------------- host layout state ----------------
  logic                   wsel_q;    // 1 warm, 0 cold secondary reset
  logic                   dbl_q;     // far-end bridge scratch flag
  link_cmd_pkg::unit_id_t dev_q;     // device number
  logic                   hide_q;    // host hidden from the chain
  logic                   endp_q;    // host_endpoint_mode as written
  logic                   endp_live_q; // host_endpoint_mode in force
  logic                   fault_q;   // far_host_termination_fault

  // warm-reset host fields: reset select, scratch, hide
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wsel_q <= `LCR_RST_WSEL;
      dbl_q  <= `LCR_RST_BIT;
      hide_q <= `LCR_RST_BIT;
    end else if (i_warm_rst) begin
      wsel_q <= `LCR_RST_WSEL;
      dbl_q  <= `LCR_RST_BIT;
      hide_q <= `LCR_RST_BIT;
    end else begin
      // low byte: reset select and scratch flag
      if (wr_lo & wr_host) begin
        wsel_q <= i_cfg_wdata[`LCR_WSEL_BIT];
        dbl_q  <= i_cfg_wdata[`LCR_DBL_BIT];
      end
      // high byte: hide control
      if (wr_hi & wr_host) begin
        hide_q <= i_cfg_wdata[`LCR_HIDE_BIT];
      end
    end
  end

  // cold-reset host fields: device number and endpoint mode
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      dev_q  <= `LCR_RST_DEV;
      endp_q <= `LCR_RST_BIT;
    end else begin
      // device number in low byte
      if (wr_lo & wr_host) begin
        dev_q <= i_cfg_wdata[`LCR_DEV_MSB:`LCR_DEV_LSB];
      end
      // endpoint request in high byte
      if (wr_hi & wr_host) begin
        endp_q <= i_cfg_wdata[`LCR_ENDP_BIT];
      end
    end
  end

  // endpoint mode takes effect only when a warm reset passes
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      endp_live_q <= `LCR_RST_BIT;
    end else if (i_warm_rst) begin
      endp_live_q <= endp_q;
    end
  end

  // fault flag: hardware set wins over a write-one clear
  wire logic fault_clr;  // write of one to the fault bit
  wire logic fault_d;    // next fault flag
  assign fault_clr = wr_hi & wr_host & i_cfg_wdata[`LCR_FAULT_BIT];
  assign fault_d   = (IS_HOST & i_far_eoc_err) | (fault_q & ~fault_clr);

  // fault register, cold reset only
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      fault_q <= `LCR_RST_BIT;
    end else begin
      fault_q <= fault_d;
    end
  end

  // ---------------- read image ----------------
  wire logic [15:0] img_slave;  // slave layout word
  wire logic [15:0] img_host;   // host layout word
  wire logic [15:0] img;        // selected word

  // unassigned positions are constant zero
  assign img_slave = {type_code, drop_q, dir_q, master_q,
                      UNIT_COUNT, base_q};
  assign img_host  = {type_code, drop_q, fault_q, endp_q, 1'b0, hide_q,
                      i_cfg_from_chain, dev_q, dbl_q, wsel_q};
  assign img       = IS_HOST ? img_host : img_slave;

  // read data registered; other addresses answer zero
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_cfg_rdata  <= 16'h0000;
      o_cfg_rvalid <= 1'b0;
    end else begin
      o_cfg_rdata  <= hit_rd ? img : 16'h0000;
      o_cfg_rvalid <= i_cfg_rd;
    end
  end

  // ---------------- identity and claiming ----------------
  wire logic [5:0] top_id;     // base plus count minus one
  wire logic       slave_claim; // device number inside owned range
  wire logic       host_claim;  // host answers this access

  assign top_id      = {1'b0, base_q} + {1'b0, UNIT_COUNT} - 6'h01;
  assign slave_claim = (i_cfg_dev >= base_q) &&
                       ({1'b0, i_cfg_dev} <= top_id);
  assign host_claim  = i_cfg_from_chain ? (~hide_q & (i_cfg_dev == dev_q)) : 1'b1;

  // claim and hiding are handshake-style combinational outputs
  assign o_cfg_claim  = IS_HOST ? host_claim : slave_claim;
  assign o_cfg_as_eoc = IS_HOST & i_cfg_from_chain & hide_q;

  // stamped identifier and bridge flag
  assign o_unit_id     = IS_HOST ? (endp_live_q ? dev_q : 5'h00) : base_q;
  assign o_bridge_flag = IS_HOST & ~endp_live_q;

  // request link: toward master host or away from it
  assign o_req_link = dir_q ? ~master_q : master_q;

  // zero asks the reset sequencer to drop the power_good_signal
  assign o_cold_reset_sel = IS_HOST & ~wsel_q;

  // ---------------- per-link initialisation and forwarding ----------------
  logic [1:0] init_q;   // initialisation complete per link

  // init flag sets only when both directions succeeded
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      init_q <= 2'b00;
    end else if (i_warm_rst) begin
      init_q <= 2'b00;
    end else begin
      init_q <= init_q | (i_rx_init_ok & i_tx_init_ok);
    end
  end

  assign o_init_done = init_q;

  // one forwarding decision and stall timer per link
  genvar gl;
  generate
    for (gl = 0; gl < 2; gl++) begin : g_link
      logic [15:0] cnt_q;     // cycles spent stalled
      logic        tmo_q;     // stall timed out on this link
      wire logic   stalled;   // link waits on initialisation

      // both flags clear and dropping off: the packet waits
      assign stalled = ~i_link_eoc[gl] & ~init_q[gl] & ~drop_q & i_pkt_pending[gl];

      // terminus reject beats forward, forward beats drop or timeout reject and stall
      assign o_link_action[gl] =
        i_link_eoc[gl]     ? link_cmd_pkg::ACT_REJECT :
        init_q[gl]         ? link_cmd_pkg::ACT_FORWARD :
        (drop_q | tmo_q)   ? link_cmd_pkg::ACT_REJECT :
                             link_cmd_pkg::ACT_STALL;

      // timer runs while stalled, releases the wait at the limit
      always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
          cnt_q <= `LCR_RST_CNT;
          tmo_q <= 1'b0;
        end else if (i_warm_rst | ~stalled) begin
          cnt_q <= `LCR_RST_CNT;
          tmo_q <= 1'b0;
        end else if (cnt_q == 16'(STALL_LIMIT - 1)) begin
          tmo_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end
    end
  endgenerate

  // software keeps the reset select steady during a bus reset;
  // the select is passed on as stored without further guard

endmodule

`default_nettype wire

// >>> logic/link_cmd_cfg.svh
// offsets, field positions, reset values and counts of the link command register
`ifndef LINK_CMD_CFG_SVH
`define LINK_CMD_CFG_SVH
// byte offset of the command register in configuration space
`define LCR_CMD_OFFSET 8'h02
// capability type field, bits 15:13
`define LCR_TYPE_MSB 15
`define LCR_TYPE_LSB 13
`define LCR_TYPE_SLAVE 3'h0
`define LCR_TYPE_HOST 3'h1
// five-bit codes of other capability blocks
`define LCR_TYPE5_SWITCH 5'h08
`define LCR_TYPE5_REVID 5'h11
`define LCR_TYPE5_RSV_A_LO 5'h09
`define LCR_TYPE5_RSV_A_HI 5'h0f
`define LCR_TYPE5_RSV_B_LO 5'h1d
`define LCR_TYPE5_RSV_B_HI 5'h1f
// slave layout positions
`define LCR_BASE_MSB 4
`define LCR_BASE_LSB 0
`define LCR_COUNT_MSB 9
`define LCR_COUNT_LSB 5
`define LCR_MASTER_BIT 10
`define LCR_DIR_BIT 11
`define LCR_DROP_BIT 12
// host layout positions
`define LCR_WSEL_BIT 0
`define LCR_DBL_BIT 1
`define LCR_DEV_MSB 6
`define LCR_DEV_LSB 2
`define LCR_SIDE_BIT 7
`define LCR_HIDE_BIT 8
`define LCR_ENDP_BIT 10
`define LCR_FAULT_BIT 11
// reset values
`define LCR_RST_BASE 5'h00
`define LCR_RST_DEV 5'h00
`define LCR_RST_WSEL 1'b1
`define LCR_RST_BIT 1'b0
`define LCR_RST_CNT 16'h0000
// default stall limit before a waiting packet is rejected, in cycles
`define LCR_STALL_LIMIT 1024
`endif

// >>> logic/link_cmd_pkg.sv
// types of the link command register
`default_nettype none
package link_cmd_pkg;
  // disposition of a packet waiting for a transmit link
  typedef enum logic [1:0] {
    ACT_FORWARD,
    ACT_STALL,
    ACT_REJECT
  } link_action_e;
  // unit identifier / device number
  typedef logic [4:0] unit_id_t;
endpackage
`default_nettype wire

// >>> test/link_cmd_reg_checker.sv
// assertions on the ports of the link command register
`timescale 1ns/1ns
`default_nettype none
module link_cmd_reg_checker #(
  parameter bit                     IS_HOST    = 1'b0,
  parameter link_cmd_pkg::unit_id_t UNIT_COUNT = 5'h01
) (
  input wire logic                       i_clk_sys,
  input wire logic                       i_rst,
  input wire logic                       i_warm_rst,
  input wire logic                       i_cfg_wr,
  input wire logic                       i_cfg_rd,
  input wire logic [7:0]                 i_cfg_addr,
  input wire logic [1:0]                 i_cfg_be,
  input wire logic [15:0]                i_cfg_wdata,
  input wire logic                       i_cfg_link,
  input wire logic [1:0]                 i_link_eoc,
  input wire logic [1:0]                 i_rx_init_ok,
  input wire logic [1:0]                 i_tx_init_ok,
  input wire logic [15:0]                o_cfg_rdata,
  input wire logic                       o_cfg_rvalid,
  input wire link_cmd_pkg::unit_id_t     o_unit_id,
  input wire logic                       o_req_link,
  input wire logic [1:0]                 o_init_done,
  input wire link_cmd_pkg::link_action_e o_link_action [2]
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // reads elsewhere answer zero one cycle on
  miss_zero_a: assert property (i_cfg_rd && i_cfg_addr != 8'h02 |=> o_cfg_rvalid && o_cfg_rdata == 16'h0000)
    else $error("miss read not zero");
  // the layout code never moves
  type_code_a: assert property (i_cfg_rd && i_cfg_addr == 8'h02 |=> o_cfg_rdata[15:13] == {2'b00, IS_HOST})
    else $error("type code wrong");
  // slave count field is fixed
  unit_count_a: assert property (!IS_HOST && i_cfg_rd && i_cfg_addr == 8'h02 |=> o_cfg_rdata[9:5] == UNIT_COUNT)
    else $error("unit count wrong");
  // a write takes the link it came on and the direction
  write_link_a: assert property (!IS_HOST && i_cfg_wr && i_cfg_addr == 8'h02 && i_cfg_be[1] && !i_warm_rst
    |=> o_req_link == ($past(i_cfg_link) ^ $past(i_cfg_wdata[11]))) else $error("request link wrong");
  // warm reset clears base, direction and master
  warm_clear_a: assert property (!IS_HOST && i_warm_rst |=> o_unit_id == 5'h00 && !o_req_link)
    else $error("warm reset left fields");
  // terminus always wins
  eoc_reject_a: assert property (i_link_eoc[1] |-> o_link_action[1] == link_cmd_pkg::ACT_REJECT)
    else $error("terminus not rejected");
  // initialised link forwards
  init_fwd_a: assert property (!i_link_eoc[0] && o_init_done[0] |-> o_link_action[0] == link_cmd_pkg::ACT_FORWARD)
    else $error("init link not forwarding");
  // init flag follows both halves done
  init_set_a: assert property (!i_warm_rst && i_rx_init_ok[0] && i_tx_init_ok[0] |=> o_init_done[0])
    else $error("init flag not set");
  cover property (i_cfg_wr && i_cfg_addr == 8'h02);
  cover property (i_warm_rst);
  cover property (o_link_action[0] == link_cmd_pkg::ACT_STALL);
endmodule
bind link_cmd_reg link_cmd_reg_checker #(.IS_HOST(IS_HOST), .UNIT_COUNT(UNIT_COUNT)) chk_u (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_warm_rst(i_warm_rst), .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd),
  .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be), .i_cfg_wdata(i_cfg_wdata), .i_cfg_link(i_cfg_link),
  .i_link_eoc(i_link_eoc), .i_rx_init_ok(i_rx_init_ok), .i_tx_init_ok(i_tx_init_ok),
  .o_cfg_rdata(o_cfg_rdata), .o_cfg_rvalid(o_cfg_rvalid), .o_unit_id(o_unit_id), .o_req_link(o_req_link),
  .o_init_done(o_init_done), .o_link_action(o_link_action));
`default_nettype wire

// >>> test/link_cmd_reg_test.sv
// self-checking bench of the link command register, slave and host layouts
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module link_cmd_reg_test;
  localparam logic [4:0] UC = 5'h03;               // identifiers owned
  logic        clk, rst, wrst, wr, rd, lnk;        // clock, resets, strobes, link
  logic [7:0]  addr;                               // register offset
  logic [1:0]  be, eoc, rxo, txo, pend, idn;       // enables, per-link state
  logic [15:0] wd, rdat;                           // write and read data
  logic [4:0]  dev, uid, base_m;                   // device, unit id, expected base
  logic        rv, clm, rql, dir_m, mst_m, drop_m; // outputs and expected bits
  logic        chn, ferr, seoc, sbrg, scold;       // chain side, far fault, slave extras
  logic        hrv, hclm, heoc, hbrg, hcold;       // host layout outputs
  logic        wsel_h, dbl_h, hide_h, endp_h;      // expected host bits
  logic        live_h, flt_h;                      // expected endpoint in force, fault
  logic [4:0]  dev_h, huid;                        // expected device number, host unit id
  logic [15:0] hrdat;                              // host read data
  logic [31:0] r, seed;                            // random word and seed
  link_cmd_pkg::link_action_e act [2];             // per-link disposition
  link_cmd_pkg::link_action_e hact [2];            // host per-link disposition
  int          mismatches, samples_checked, cyc;   // counters
  link_cmd_reg #(.IS_HOST(1'b0), .UNIT_COUNT(UC), .STALL_LIMIT(8)) dut_u (
    .i_clk_sys(clk), .i_rst(rst), .i_warm_rst(wrst), .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr),
    .i_cfg_be(be), .i_cfg_wdata(wd), .i_cfg_link(lnk), .i_cfg_from_chain(chn), .i_cfg_dev(dev),
    .i_link_eoc(eoc), .i_rx_init_ok(rxo), .i_tx_init_ok(txo), .i_pkt_pending(pend), .i_far_eoc_err(ferr),
    .o_cfg_rdata(rdat), .o_cfg_rvalid(rv), .o_cfg_claim(clm), .o_cfg_as_eoc(seoc), .o_unit_id(uid),
    .o_bridge_flag(sbrg), .o_req_link(rql), .o_cold_reset_sel(scold), .o_init_done(idn), .o_link_action(act));
  // host layout copy on the same bus and link inputs
  link_cmd_reg #(.IS_HOST(1'b1), .UNIT_COUNT(UC), .STALL_LIMIT(8)) host_u (
    .i_clk_sys(clk), .i_rst(rst), .i_warm_rst(wrst), .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr),
    .i_cfg_be(be), .i_cfg_wdata(wd), .i_cfg_link(lnk), .i_cfg_from_chain(chn), .i_cfg_dev(dev),
    .i_link_eoc(eoc), .i_rx_init_ok(rxo), .i_tx_init_ok(txo), .i_pkt_pending(pend), .i_far_eoc_err(ferr),
    .o_cfg_rdata(hrdat), .o_cfg_rvalid(hrv), .o_cfg_claim(hclm), .o_cfg_as_eoc(heoc), .o_unit_id(huid),
    .o_bridge_flag(hbrg), .o_req_link(), .o_cold_reset_sel(hcold), .o_init_done(), .o_link_action(hact));
  // image the slave layout should show
  function automatic logic [15:0] img_f();
    return {3'h0, drop_m, dir_m, mst_m, UC, base_m};
  endfunction
  // image the host layout should show; bit 7 follows the chain side input
  function automatic logic [15:0] himg_f();
    return {3'h1, drop_m, flt_h, endp_h, 1'b0, hide_h, chn, dev_h, dbl_h, wsel_h};
  endfunction
  // mirror of a warm reset; endpoint mode comes into force here
  task automatic warm_m();
    {base_m, dir_m, mst_m, dbl_h, hide_h} = '0;
    wsel_h = 1'b1;
    live_h = endp_h;
  endtask
  // mirror of a cold reset
  task automatic cold_m();
    warm_m();
    {drop_m, dev_h, endp_h, live_h, flt_h} = '0;
  endtask
  // disposition from terminus, init and drop
  function automatic link_cmd_pkg::link_action_e act_f(input logic e, input logic i, input logic d);
    return e ? link_cmd_pkg::ACT_REJECT : i ? link_cmd_pkg::ACT_FORWARD :
      d ? link_cmd_pkg::ACT_REJECT : link_cmd_pkg::ACT_STALL;
  endfunction
  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one write strobe; mirrors the fields it should change
  task automatic wr_t(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d, input logic l);
    @(posedge clk);
    wr <= 1'b1;
    {addr, be, wd, lnk} <= {a, b, d, l};
    @(posedge clk);
    wr <= 1'b0;
    if (a == 8'h02) begin
      mst_m = l;
      if (b[0]) base_m = d[4:0];
      if (b[1]) {drop_m, dir_m} = d[12:11];
      // bit 0 moves only while no bus reset is asserted
      if (b[0]) {dev_h, dbl_h, wsel_h} = d[6:0];
      if (b[1]) {endp_h, hide_h} = {d[10], d[8]};
      if (b[1] && d[11]) flt_h = 1'b0;
    end
  endtask
  // one read strobe with a fresh device number; checks the answer
  task automatic rd_t(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    {chn, dev} <= 6'($random(seed));
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK({rv, hrv}, 2'b11)
    `CHK(rdat, (a == 8'h02) ? img_f() : 16'h0000)
    `CHK(uid, base_m)
    `CHK(rql, dir_m ^ mst_m)
    if (base_m <= 5'h1c) `CHK(clm, dev >= base_m && dev <= base_m + UC - 5'h01)
    `CHK({seoc, sbrg, scold}, 3'b000)
    `CHK(hrdat, (a == 8'h02) ? himg_f() : 16'h0000)
    `CHK(hclm, chn ? (!hide_h && dev == dev_h) : 1'b1)
    `CHK(heoc, chn & hide_h)
    `CHK(huid, live_h ? dev_h : 5'h00)
    `CHK({hbrg, hcold}, {!live_h, !wsel_h})
  endtask
  // clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    seed = 32'hfa906b35;
    rst = 1'b1;
    {wrst, wr, rd, lnk, chn, ferr, addr, be, wd, dev, eoc, rxo, txo, pend} = '0;
    cold_m();
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_t(8'h02);
    // random hits, misses and partial enables
    repeat (80) begin
      r = $random(seed);
      if (r[0]) wr_t(r[1] ? 8'h02 : r[15:8], r[3:2], r[31:16], r[4]);
      else rd_t(r[1] ? 8'h02 : r[15:8]);
    end
    wr_t(8'h02, 2'b11, 16'h180a, 1'b0);
    wr_t(8'h02, 2'b00, 16'hffff, 1'b1); // enables off, link still taken
    rd_t(8'h02);
    wr_t(8'h02, 2'b11, 16'hffff, 1'b1); // fixed bits stay put
    rd_t(8'h02);
    // warm reset keeps the drop bit, and in the host layout also device number, endpoint request and fault
    @(posedge clk);
    wrst <= 1'b1;
    @(posedge clk);
    wrst <= 1'b0;
    warm_m();
    rd_t(8'h02);
    // cold reset clears drop as well
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    cold_m();
    rd_t(8'h02);
    // far host fault, then a clear in the same cycle as a set loses
    @(posedge clk);
    ferr <= 1'b1;
    wr_t(8'h02, 2'b10, 16'h0800, 1'b0);
    ferr <= 1'b0;
    flt_h = 1'b1;
    rd_t(8'h02);
    wr_t(8'h02, 2'b10, 16'h0800, 1'b0);
    rd_t(8'h02);
    // every terminus and drop pairing on an uninitialised link
    for (int k = 0; k < 4; k++) begin
      wr_t(8'h02, 2'b10, {3'h0, k[1], 12'h000}, 1'b0);
      eoc <= {1'b0, k[0]};
      @(posedge clk);
      #1;
      `CHK(act[0], act_f(k[0], 1'b0, k[1]))
      `CHK(hact[0], act_f(k[0], 1'b0, k[1]))
    end
    @(posedge clk);
    {rxo, txo, eoc} <= 6'h3c;
    repeat (2) @(posedge clk);
    #1;
    `CHK(act[0], link_cmd_pkg::ACT_FORWARD)
    @(posedge clk);
    eoc <= 2'b01;
    #1;
    `CHK(act[0], link_cmd_pkg::ACT_REJECT)
    // a link that never initialises gives up after the stall limit
    @(posedge clk);
    {rxo, txo, eoc} <= '0;
    wr_t(8'h02, 2'b10, 16'h0000, 1'b0);
    wrst <= 1'b1;
    @(posedge clk);
    wrst <= 1'b0;
    pend <= 2'b01;
    warm_m();
    @(posedge clk);
    #1;
    `CHK(act[0], link_cmd_pkg::ACT_STALL)
    `CHK(idn, 2'b00)
    repeat (12) @(posedge clk);
    #1;
    `CHK(act[0], link_cmd_pkg::ACT_REJECT)
    rd_t(8'h02);
    tally_and_finish();
  end
endmodule
`default_nettype wire
